/* hw/ustat_pkg.sv */
/*
 * ustat_pkg: register offsets, field positions and reset values for the
 * uart status and interrupt-flag block.
 * assumes: word-addressed byte offsets on a plain strobe register port.
 */
package ustat_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFF_MODEM_LINE_STATUS = 8'h14;
    localparam logic [7:0]  OFF_FIFO_STATUS       = 8'h18;
    localparam logic [7:0]  OFF_INTERRUPT_STATUS  = 8'h1C;
    localparam logic [7:0]  OFF_IRQ_ENABLE        = 8'h04;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          MLS_CHANGE_BIT  = 0;
    localparam int          MLS_PIN_BIT     = 4;
    localparam int          MLS_LEVSEL_BIT  = 8;
    localparam int          FS_RXOVR_BIT    = 0;
    localparam int          FS_PAR_BIT      = 4;
    localparam int          FS_FRM_BIT      = 5;
    localparam int          FS_BRK_BIT      = 6;
    localparam int          FS_RXLEV_LSB    = 8;
    localparam int          FS_RXEMPTY_BIT  = 14;
    localparam int          FS_RXFULL_BIT   = 15;
    localparam int          FS_TXLEV_LSB    = 16;
    localparam int          FS_TXEMPTY_BIT  = 22;
    localparam int          FS_TXFULL_BIT   = 23;
    localparam int          FS_TXOVR_BIT    = 24;
    localparam int          FS_IDLE_BIT     = 28;
    localparam int          IS_IND_LSB      = 8;
    // enable bit order: 0 rx avail,1 tx empty,2 line,3 modem,4 tout,5 buf,8 lin
    localparam int          IRQ_SRC_COUNT   = 8;
    // ------------------------------------------------------------------
    // reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_FIFO_STATUS      = 32'h1040_4000;
    localparam logic [31:0] RST_INTERRUPT_STATUS = 32'h0000_0002;
    localparam logic [31:0] RST_MODEM_LINE       = 32'h0000_0110;
    localparam int          FIFO_DEPTH_DEF       = 16;
endpackage

/* hw/ustat_sync.sv */
/*
 * ustat_sync: two-flop synchroniser for one asynchronous level.
 * assumes: a single clock domain downstream; resets high, the idle line level.
 */
`timescale 1ns/1ps
module ustat_sync
    import ustat_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic stage1;
    logic next_stage1;
    logic next_dout;

    // the first stage feeds only the second, never any logic
    always_comb
    begin
        next_stage1 = din;
        next_dout   = stage1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // idle-high reset so an undisturbed line shows no false edge
            stage1 <= 1'b1;
            dout   <= 1'b1;
        end
        else
        begin
            stage1 <= next_stage1;
            dout   <= next_dout;
        end
    end
endmodule

/* hw/ustat_core.sv */
/*
 * ustat_core: status and interrupt-flag logic of a uart; cts watch, fifo
 * occupancy, receive error flags and interrupt indicators.
 * assumes: datapath pulses (writes, pops, pushes, errors) are one cycle on
 * clk; cts pin is asynchronous and passes a two-flop synchroniser.
 */
// Functional notes
// RULE1: cts active level chosen by select bit
// RULE2: pin level bit mirrors raw cts pin; the code mirrors the synchronised pin, and only while cts_func_sel is set
// RULE3: cts change sets flag, write-one clears
// RULE4: write while tx full sets overflow
// RULE5: idle flag when fifo empty, shifter done
// RULE6: tx full exactly at sixteen bytes
// RULE7: tx empty on last pop, cleared by write
// RULE8: tx level counts, shows zero when full
// RULE9: rx full exactly at sixteen bytes
// RULE10: rx empty on last read, cleared on receive
// RULE11: rx level counts, shows zero when full
// RULE12: break flag, cleared by write or reset
// RULE13: framing flag, cleared by write or reset
// RULE14: parity flag set on parity mismatch
// RULE15: indicators are enable and flag
// RULE16: rx available indicator is enable and flag
// RULE17: modem flag follows cts change flag
// RULE18: buffer error while either overflow set
// RULE19: line flag while any error set
// RULE20: one irq output ORs all indicators
`timescale 1ns/1ps
module ustat_core
    import ustat_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH_DEF
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        cts_pin,
    input  wire logic        cts_func_sel,
    input  wire logic        tx_holding_port_wr,
    input  wire logic        tx_pop,
    input  wire logic        tx_shift_busy,
    input  wire logic        rx_push,
    input  wire logic        rx_cpu_read,
    input  wire logic        rx_overflow,
    input  wire logic        rx_break_det,
    input  wire logic        rx_frame_err,
    input  wire logic        rx_parity_err,
    input  wire logic        rx_fifo_reset,
    input  wire logic        rx_avail_flag,
    input  wire logic        rx_timeout_flag,
    input  wire logic        lin_break_flag,
    output logic             cts_active,
    output logic             irq
);
    localparam int LW = $clog2(DEPTH) + 1;
    localparam logic [LW-1:0] FULL_CNT = LW'(DEPTH);

    // ------------------------------------------------------------------
    // cts synchroniser
    // ------------------------------------------------------------------
    logic cts_sync;
    ustat_sync u_cts_sync
    (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (cts_pin),
        .dout  (cts_sync)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic          cts_active_low_sel, next_cts_active_low_sel;
    logic          cts_pin_level,      next_cts_pin_level;
    logic          cts_change_flag,    next_cts_change_flag;
    logic          tx_overflow_flag,   next_tx_overflow_flag;
    logic          rx_overflow_flag,   next_rx_overflow_flag;
    logic          rx_break_flag,      next_rx_break_flag;
    logic          rx_frame_err_flag,  next_rx_frame_err_flag;
    logic          rx_parity_err_flag, next_rx_parity_err_flag;
    logic          tx_empty_event_flag, next_tx_empty_event_flag;
    logic [LW-1:0] tx_count,           next_tx_count;
    logic [LW-1:0] rx_count,           next_rx_count;
    logic [IRQ_SRC_COUNT-1:0] irq_en,  next_irq_en;
    logic [31:0]   next_reg_rdata;

    // ------------------------------------------------------------------
    // derived status
    // ------------------------------------------------------------------
    logic          tx_full, rx_full, tx_empty, rx_empty, tx_fully_idle_flag;
    logic          buf_err_flag, line_status_flag, modem_flag;
    logic [5:0]    tx_level, rx_level;
    logic [IRQ_SRC_COUNT-1:0] src_flag, irq_ind;
    logic          wr_mls, wr_fs, wr_ier;

    // RULE6 tx full at depth
    assign tx_full  = (tx_count == FULL_CNT);
    // RULE9 rx full at depth
    assign rx_full  = (rx_count == FULL_CNT);
    // RULE7 empty tracks occupancy: set by last pop, cleared by a write
    assign tx_empty = (tx_count == '0);
    // RULE10 rx empty by last read, cleared by a push
    assign rx_empty = (rx_count == '0);
    // RULE8 level reads zero while full, so only four bits show
    assign tx_level = tx_full ? 6'h00 : 6'(tx_count);
    // RULE11 same wrap for the receive level
    assign rx_level = rx_full ? 6'h00 : 6'(rx_count);
    // RULE5 idle only when queue empty and the stop bit is out
    assign tx_fully_idle_flag = tx_empty && !tx_shift_busy;
    // RULE18 buffer error from either overflow
    assign buf_err_flag     = tx_overflow_flag || rx_overflow_flag;
    // RULE19 line status from any receive error
    assign line_status_flag = rx_break_flag || rx_frame_err_flag || rx_parity_err_flag;
    // RULE17 modem flag is the cts change flag
    assign modem_flag       = cts_change_flag;
    // RULE1 active level select
    assign cts_active       = cts_sync ^ cts_active_low_sel;

    // source flags in enable order; bits 6 and 7 carry lin break only at 7
    assign src_flag = {lin_break_flag, 1'b0, buf_err_flag, rx_timeout_flag,
                       modem_flag, line_status_flag, tx_empty_event_flag,
                       rx_avail_flag};
    // RULE15 each indicator is enable and flag
    // RULE16 rx available included at bit 0
    assign irq_ind = irq_en & src_flag;
    // RULE20 single request is or of indicators
    assign irq = |irq_ind;

    assign wr_mls = reg_wr && (reg_addr == OFF_MODEM_LINE_STATUS);
    assign wr_fs  = reg_wr && (reg_addr == OFF_FIFO_STATUS);
    assign wr_ier = reg_wr && (reg_addr == OFF_IRQ_ENABLE);

    // flag and counter next values; a hardware set beats a clear, except the tx empty event, where a write beats the last pop
    always_comb
    begin
        next_cts_active_low_sel = cts_active_low_sel;
        next_irq_en             = irq_en;
        if (wr_mls)
            next_cts_active_low_sel = reg_wdata[MLS_LEVSEL_BIT];
        if (wr_ier)
            next_irq_en = {reg_wdata[8], 1'b0, reg_wdata[5:0]};
        // RULE2 mirror tracks only while pin function is selected
        next_cts_pin_level = cts_func_sel ? cts_sync : cts_pin_level;
        // RULE3 any cts edge sets while the pin function is selected, write one clears
        next_cts_change_flag = (cts_change_flag && !(wr_mls && reg_wdata[MLS_CHANGE_BIT]))
                               || (cts_func_sel && (cts_sync != cts_pin_level));
        // RULE4 overflow on write into a full queue
        next_tx_overflow_flag = (tx_overflow_flag && !(wr_fs && reg_wdata[FS_TXOVR_BIT]))
                                || (tx_holding_port_wr && tx_full);
        next_rx_overflow_flag = (rx_overflow_flag && !(wr_fs && reg_wdata[FS_RXOVR_BIT]))
                                || rx_overflow;
        // RULE12 break cleared by write one or fifo reset
        next_rx_break_flag = (rx_break_flag && !(wr_fs && reg_wdata[FS_BRK_BIT])
                              && !rx_fifo_reset) || rx_break_det;
        // RULE13 framing cleared by write one or fifo reset
        next_rx_frame_err_flag = (rx_frame_err_flag && !(wr_fs && reg_wdata[FS_FRM_BIT])
                                  && !rx_fifo_reset) || rx_frame_err;
        // RULE14 parity set on mismatch
        next_rx_parity_err_flag = (rx_parity_err_flag && !(wr_fs && reg_wdata[FS_PAR_BIT])
                                   && !rx_fifo_reset) || rx_parity_err;
        // RULE7 event flag set on last pop, cleared by a new write
        next_tx_empty_event_flag = tx_empty_event_flag;
        if (tx_holding_port_wr && !tx_full)
            next_tx_empty_event_flag = 1'b0;
        else if (tx_pop && tx_count == LW'(1))
            next_tx_empty_event_flag = 1'b1;
        // RULE8 tx count up on write, down on pop; writes into full dropped
        next_tx_count = tx_count;
        if ((tx_holding_port_wr && !tx_full) && !(tx_pop && !tx_empty))
            next_tx_count = tx_count + LW'(1);
        else if (!(tx_holding_port_wr && !tx_full) && (tx_pop && !tx_empty))
            next_tx_count = tx_count - LW'(1);
        // RULE11 rx count up on push, down on read; fifo reset empties it
        next_rx_count = rx_count;
        if (rx_fifo_reset)
            next_rx_count = '0;
        else if ((rx_push && !rx_full) && !(rx_cpu_read && !rx_empty))
            next_rx_count = rx_count + LW'(1);
        else if (!(rx_push && !rx_full) && (rx_cpu_read && !rx_empty))
            next_rx_count = rx_count - LW'(1);
        // register read mux; unmapped addresses read zero
        next_reg_rdata = 32'h0000_0000;
        if (reg_rd)
        begin
            case (reg_addr)
                OFF_MODEM_LINE_STATUS:
                begin
                    next_reg_rdata[MLS_LEVSEL_BIT] = cts_active_low_sel;
                    next_reg_rdata[MLS_PIN_BIT]    = cts_pin_level;
                    next_reg_rdata[MLS_CHANGE_BIT] = cts_change_flag;
                end
                OFF_FIFO_STATUS:
                begin
                    next_reg_rdata[FS_IDLE_BIT]    = tx_fully_idle_flag;
                    next_reg_rdata[FS_TXOVR_BIT]   = tx_overflow_flag;
                    next_reg_rdata[FS_TXFULL_BIT]  = tx_full;
                    next_reg_rdata[FS_TXEMPTY_BIT] = tx_empty;
                    next_reg_rdata[FS_TXLEV_LSB+:6] = tx_level;
                    next_reg_rdata[FS_RXFULL_BIT]  = rx_full;
                    next_reg_rdata[FS_RXEMPTY_BIT] = rx_empty;
                    next_reg_rdata[FS_RXLEV_LSB+:6] = rx_level;
                    next_reg_rdata[FS_BRK_BIT]     = rx_break_flag;
                    next_reg_rdata[FS_FRM_BIT]     = rx_frame_err_flag;
                    next_reg_rdata[FS_PAR_BIT]     = rx_parity_err_flag;
                    next_reg_rdata[FS_RXOVR_BIT]   = rx_overflow_flag;
                end
                OFF_INTERRUPT_STATUS:
                begin
                    next_reg_rdata[IRQ_SRC_COUNT-1:0] = src_flag;
                    next_reg_rdata[IS_IND_LSB+:IRQ_SRC_COUNT] = irq_ind;
                end
                OFF_IRQ_ENABLE:
                begin
                    // lin enable sits at bit 8 of the word, top bit inside
                    next_reg_rdata[5:0] = irq_en[5:0];
                    next_reg_rdata[8]   = irq_en[IRQ_SRC_COUNT-1];
                end
                default:
                begin
                    next_reg_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // registering only; reset values match the documented register resets
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // select and mirror reset as for an idle-high line
            cts_active_low_sel  <= RST_MODEM_LINE[MLS_LEVSEL_BIT];
            cts_pin_level       <= RST_MODEM_LINE[MLS_PIN_BIT];
            cts_change_flag     <= RST_MODEM_LINE[MLS_CHANGE_BIT];
            tx_overflow_flag    <= 1'b0;
            rx_overflow_flag    <= 1'b0;
            rx_break_flag       <= 1'b0;
            rx_frame_err_flag   <= 1'b0;
            rx_parity_err_flag  <= 1'b0;
            tx_empty_event_flag <= 1'b1;
            tx_count            <= '0;
            rx_count            <= '0;
            irq_en              <= '0;
            reg_rdata           <= 32'h0000_0000;
        end
        else
        begin
            cts_active_low_sel  <= next_cts_active_low_sel;
            cts_pin_level       <= next_cts_pin_level;
            cts_change_flag     <= next_cts_change_flag;
            tx_overflow_flag    <= next_tx_overflow_flag;
            rx_overflow_flag    <= next_rx_overflow_flag;
            rx_break_flag       <= next_rx_break_flag;
            rx_frame_err_flag   <= next_rx_frame_err_flag;
            rx_parity_err_flag  <= next_rx_parity_err_flag;
            tx_empty_event_flag <= next_tx_empty_event_flag;
            tx_count            <= next_tx_count;
            rx_count            <= next_rx_count;
            irq_en              <= next_irq_en;
            reg_rdata           <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    AST_TX_OVF: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        tx_holding_port_wr && tx_full |=> tx_overflow_flag)
        else $error("tx overflow flag not set");
    AST_CTS_CHG: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        cts_func_sel && $changed(cts_pin_level) |-> cts_change_flag)
        else $error("cts change not flagged");
    AST_TX_FULL: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        tx_full |-> tx_level == 6'h00 && !tx_empty)
        else $error("tx full level wrong");
    AST_RX_LEV: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
        rx_push && !rx_cpu_read && !rx_full && !rx_fifo_reset |=> rx_count == $past(rx_count) + LW'(1))
        else $error("rx level did not count");
    AST_BRK_CLR: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        rx_fifo_reset && !rx_break_det |=> !rx_break_flag)
        else $error("break flag survived fifo reset");
    AST_IDLE: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
        tx_fully_idle_flag |-> tx_count == '0 && !tx_shift_busy)
        else $error("idle with work pending");
    AST_BUFERR: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
        $fell(tx_overflow_flag) && !rx_overflow_flag |-> !buf_err_flag)
        else $error("buffer error stuck");
    AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n) // RULE20
        irq_en[3] && cts_change_flag |-> irq)
        else $error("modem irq missing");
    AST_READ: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        reg_rd && reg_addr == OFF_MODEM_LINE_STATUS |=> reg_rdata[MLS_PIN_BIT] == $past(cts_pin_level))
        else $error("pin level readback wrong");
    // last byte leaving the queue raises the empty event
    AST_TX_EVT: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        tx_pop && !tx_holding_port_wr && tx_count == LW'(1) |=> tx_empty_event_flag)
        else $error("tx empty event not set");
    // last cpu read leaves the receive queue empty
    AST_RX_EMPTY: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
        rx_cpu_read && !rx_push && rx_count == LW'(1) && !rx_fifo_reset |=> rx_empty)
        else $error("rx empty not set on last read");
endmodule

/* verif/ustat_cts_dev.sv */
/*
 * ustat_cts_dev: model of the far serial device that drives the
 * clear-to-send line of the uart.
 * assumes: the bench commands the wanted line level; the model moves the
 * pin off the bench clock grid, quickly or slowly as asked.
 */
`timescale 1ns/1ps
module ustat_cts_dev
(
    input  wire logic want,
    input  wire logic slow,
    output logic      cts_pin
);
    // ------------------------------------------------------------------
    // line driver
    // ------------------------------------------------------------------
    // the line idles high before anything is asked of it
    initial cts_pin = 1'b1;
    // the far side has its own clock, so edges land at odd phases;
    // the slow answer lands deep inside a later cycle of the uart clock
    always @(want)
    begin
        cts_pin <= #(slow ? 47 : 3) want;
    end
endmodule

/* verif/ustat_core_tb.sv */
/*
 * ustat_core_tb: self-checking bench for the uart status and flag block.
 * assumes: ustat_pkg and ustat_core compiled first; the cts partner model
 * sits on the pin; datapath strobes are one-cycle pulses from the bench.
 */
`timescale 1ns/1ps
module ustat_core_tb
    import ustat_pkg::*;
;
    logic        clk, rst_n, reg_wr, reg_rd, tx_busy, want, slow, cts_active, irq, fsel;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [8:0]  p;
    logic [2:0]  lv;
    logic [63:0] e;
    logic [63:0] q[$];
    logic        rd_pend;
    wire         cts_pin;
    int          n_mismatch, n_checks, seed, n;
    localparam logic [31:0] TXM = 32'h11FF_0000;
    localparam logic [31:0] RXM = 32'h0000_FF71;

    // ------------------------------------------------------------------
    // design and partner
    // ------------------------------------------------------------------
    ustat_core #(.DEPTH(16)) ustat_core_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cts_pin(cts_pin), .cts_func_sel(fsel), .tx_holding_port_wr(p[0]), .tx_pop(p[1]),
        .tx_shift_busy(tx_busy), .rx_push(p[2]), .rx_cpu_read(p[3]), .rx_overflow(p[8]),
        .rx_break_det(p[4]), .rx_frame_err(p[5]), .rx_parity_err(p[6]),
        .rx_fifo_reset(p[7]), .rx_avail_flag(lv[0]), .rx_timeout_flag(lv[1]),
        .lin_break_flag(lv[2]), .cts_active(cts_active), .irq(irq));
    ustat_cts_dev ustat_cts_dev_i (.want(want), .slow(slow), .cts_pin(cts_pin));

    // ------------------------------------------------------------------
    // clock, time-zero values, run limit
    // ------------------------------------------------------------------
    initial
    begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        {rst_n, reg_wr, reg_rd, tx_busy, slow, rd_pend} = '0;
        {want, fsel} = 2'b11;
        {reg_addr, reg_wdata, p, lv} = '0;
        seed = 47052;
        repeat (100000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // compare tasks and closing report
    // ------------------------------------------------------------------
    task chk_rd(input logic [31:0] x, input logic [31:0] m);
        n_checks++;
        if ((reg_rdata & m) !== x)
        begin
            n_mismatch++;
            $display("unexpected rdata at %0t: got %h exp %h", $time, reg_rdata & m, x);
        end
    endtask
    task chk_bit(input logic s, input logic v);
        n_checks++;
        if (s !== v)
        begin
            n_mismatch++;
            $display("unexpected level at %0t: got %h exp %h", $time, s, v);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // bus and datapath drivers
    // ------------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // the expected word is noted when the read is issued
    task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        q.push_back({x, m});
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task pulse(input int b, input int k);
        repeat (k)
        begin
            @(posedge clk);
            p[b] <= 1'b1;
            @(posedge clk);
            p[b] <= 1'b0;
        end
    endtask
    // bounded wait: a level that never comes is a mismatch and ends the run
    task await_sig(input int which, input logic v);
        int k;
        logic s;
        for (k = 0; k < 20; k++)
        begin
            @(negedge clk);
            s = (which != 0) ? irq : cts_active;
            if (s === v)
                break;
        end
        chk_bit(s, v);
        if (k == 20)
            end_sim();
    endtask
    task done(input string s);
        $display("test %0s done", s);
    endtask

    // ------------------------------------------------------------------
    // read monitor: data stand only in the cycle after the strobe
    // ------------------------------------------------------------------
    always @(posedge clk) rd_pend <= reg_rd;
    always @(negedge clk)
    begin
        if (rd_pend === 1'b1 && q.size() > 0)
        begin
            e = q.pop_front();
            chk_rd(e[63:32], e[31:0]);
        end
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_FIFO_STATUS, 32'h1040_4000, 32'hFFFF_FFFF);
        rd(OFF_INTERRUPT_STATUS, 32'h0000_0002, 32'h0000_FFFF);
        rd(OFF_MODEM_LINE_STATUS, 32'h0000_0110, 32'h0000_0111);
        rd(8'h30, 32'h0000_0000, 32'hFFFF_FFFF);
        done("reset");
        // cts level select, mirror, change flag and modem interrupt
        want = 1'b0;
        await_sig(0, 1'b1);
        repeat (2) @(posedge clk);
        rd(OFF_MODEM_LINE_STATUS, 32'h0000_0101, 32'h0000_0111);
        wr(OFF_IRQ_ENABLE, 32'h0000_0008);
        await_sig(1, 1'b1);
        rd(OFF_INTERRUPT_STATUS, 32'h0000_0808, 32'h0000_0808);
        wr(OFF_MODEM_LINE_STATUS, 32'h0000_0001);
        await_sig(0, 1'b0);
        await_sig(1, 1'b0);
        rd(OFF_MODEM_LINE_STATUS, 32'h0000_0000, 32'h0000_0111);
        slow = 1'b1;
        want = 1'b1;
        await_sig(0, 1'b1);
        repeat (2) @(posedge clk);
        rd(OFF_MODEM_LINE_STATUS, 32'h0000_0011, 32'h0000_0111);
        wr(OFF_MODEM_LINE_STATUS, 32'h0000_0001);
        // pin function deselected: the mirror holds and no change is seen
        @(posedge clk);
        fsel <= 1'b0;
        slow = 1'b0;
        want = 1'b0;
        await_sig(0, 1'b0);
        repeat (2) @(posedge clk);
        rd(OFF_MODEM_LINE_STATUS, 32'h0000_0010, 32'h0000_0111);
        @(posedge clk);
        fsel <= 1'b1;
        repeat (2) @(posedge clk);
        rd(OFF_MODEM_LINE_STATUS, 32'h0000_0001, 32'h0000_0111);
        wr(OFF_MODEM_LINE_STATUS, 32'h0000_0001);
        done("cts");
        // transmit queue: fill, overflow, drain with the shifter busy
        wr(OFF_IRQ_ENABLE, 32'h0000_0022);
        pulse(0, 15);
        rd(OFF_FIFO_STATUS, 32'h000F_0000, TXM);
        rd(OFF_INTERRUPT_STATUS, 32'h0000_0000, 32'h0000_0002);
        pulse(0, 1);
        rd(OFF_FIFO_STATUS, 32'h0080_0000, TXM);
        await_sig(1, 1'b0);
        pulse(0, 1);
        rd(OFF_FIFO_STATUS, 32'h0180_0000, TXM);
        await_sig(1, 1'b1);
        @(posedge clk);
        tx_busy <= 1'b1;
        pulse(1, 1);
        rd(OFF_FIFO_STATUS, 32'h010F_0000, TXM);
        pulse(1, 15);
        rd(OFF_FIFO_STATUS, 32'h0140_0000, TXM);
        @(posedge clk);
        tx_busy <= 1'b0;
        rd(OFF_FIFO_STATUS, 32'h1140_0000, TXM);
        wr(OFF_FIFO_STATUS, 32'h0100_0000);
        rd(OFF_FIFO_STATUS, 32'h1040_0000, TXM);
        wr(OFF_IRQ_ENABLE, 32'h0000_0000);
        await_sig(1, 1'b0);
        done("tx");
        // receive queue: random partial fill, full, drain by cpu reads
        n = 1 + ($unsigned($random(seed)) % 15);
        pulse(2, n);
        rd(OFF_FIFO_STATUS, n << 8, RXM);
        pulse(2, 16 - n);
        rd(OFF_FIFO_STATUS, 32'h0000_8000, RXM);
        pulse(3, 1);
        rd(OFF_FIFO_STATUS, 32'h0000_0F00, RXM);
        pulse(3, 15);
        rd(OFF_FIFO_STATUS, 32'h0000_4000, RXM);
        done("rx");
        // receive errors, line status and buffer error, both clear paths
        wr(OFF_IRQ_ENABLE, 32'h0000_0024);
        for (int b = 4; b <= 8; b++)
            if (b != 7)
                pulse(b, 1);
        rd(OFF_FIFO_STATUS, 32'h0000_4071, RXM);
        rd(OFF_INTERRUPT_STATUS, 32'h0000_2424, 32'h0000_2424);
        await_sig(1, 1'b1);
        wr(OFF_FIFO_STATUS, 32'h0000_0041);
        rd(OFF_FIFO_STATUS, 32'h0000_4030, RXM);
        rd(OFF_INTERRUPT_STATUS, 32'h0000_0404, 32'h0000_2424);
        pulse(7, 1);
        rd(OFF_FIFO_STATUS, 32'h0000_4000, RXM);
        rd(OFF_INTERRUPT_STATUS, 32'h0000_0000, 32'h0000_2424);
        await_sig(1, 1'b0);
        done("errors");
        // indicators of datapath-level sources, rx available and lin masked in one write
        wr(OFF_IRQ_ENABLE, 32'h0000_0111);
        rd(OFF_IRQ_ENABLE, 32'h0000_0111, 32'h0000_01FF);
        @(posedge clk);
        lv <= 3'h7;
        rd(OFF_INTERRUPT_STATUS, 32'h0000_9191, 32'h0000_9191);
        await_sig(1, 1'b1);
        wr(OFF_IRQ_ENABLE, 32'h0000_0010);
        rd(OFF_INTERRUPT_STATUS, 32'h0000_1091, 32'h0000_9191);
        @(posedge clk);
        lv <= 3'h0;
        rd(OFF_INTERRUPT_STATUS, 32'h0000_0000, 32'h0000_9191);
        await_sig(1, 1'b0);
        done("indicators");
        repeat (3) @(posedge clk);
        end_sim();
    end
endmodule
